// [verilog/bdu_core.sv]
// Background debug unit command core: hardware commands, halt control,
// security gating and cycle stealing on the CPU bus.
// Assumes a serial front end, CPU and memory fabric on i_sys_clk.

`timescale 1ns/100ps
`default_nettype none

module bdu_core
    import bdu_pkg::*;
(
    input wire logic i_sys_clk,                 // 125 MHz bus clock
    input wire logic i_reset_n,                 // Async reset, active low
    input wire logic i_special_mode,            // Strap: special single-chip
    input wire logic i_secured,                 // Strap: security on
    input wire logic i_cmd_valid,               // Hardware command strobe
    input wire bdu_pkg::bdu_cmd_t i_cmd,        // Hardware command fields
    input wire logic i_fw_cmd_valid,            // Firmware command strobe
    input wire logic i_erase_ok,                // Secure firmware: erased
    input wire logic i_erase_fail,              // Secure firmware: not erased
    input wire logic i_fw_resume,               // Firmware leaves halt
    input wire logic i_halt_insn,               // CPU halt instruction
    input wire logic i_ext_tag,                 // External tag reached
    input wire logic i_brk_event,               // Breakpoint force or tag
    input wire logic i_brk_after,               // Breakpoint halts after next
    input wire logic i_insn_done,               // CPU finished an instruction
    input wire logic i_cpu_bus_idle,            // Free CPU bus cycle
    input wire logic i_mem_done,                // Memory access finished
    input wire logic [15:0] i_mem_rdata,        // Memory read word
    input wire logic i_user_rd,                 // User program read strobe
    input wire logic [15:0] i_user_addr,        // User program read address
    output logic o_mem_req_valid,               // Borrowed access request
    output bdu_pkg::bdu_mem_req_t o_mem_req,    // Borrowed access fields
    output logic o_cpu_freeze,                  // Hold CPU bus
    output logic o_cpu_stall,                   // Brief stall, disabled halt
    output logic o_halt_req,                    // Halt after instruction
    output logic o_active,                      // Halted debug state
    output logic o_window_map,                  // Debug window in map
    output logic o_user_hidden,                 // User read of hidden reg
    output logic o_fw_cmd_go,                   // Firmware command may run
    output logic o_rdata_valid,                 // Read data ready, pulse
    output logic [15:0] o_rdata,                // Read data to shift out
    output logic o_busy,                        // Hardware command underway
    output logic o_ack_pulse,                   // Handshake pulse
    output logic o_debug_enable,                // Debug enable bit
    output logic o_unsecure                     // Unsecure flag
);
    import bdu_pkg::*;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic in_regs(input logic [15:0] a);
        return (a >= BDU_REG_BASE) && (a <= BDU_REG_LAST);
    endfunction

    function automatic logic is_mem_op(input logic [7:0] op);
        return (op == BDU_OP_RD_IN_BYTE) || (op == BDU_OP_RD_IN_WORD)
            || (op == BDU_OP_RD_OUT_BYTE) || (op == BDU_OP_RD_OUT_WORD)
            || (op == BDU_OP_WR_IN_BYTE) || (op == BDU_OP_WR_IN_WORD)
            || (op == BDU_OP_WR_OUT_BYTE) || (op == BDU_OP_WR_OUT_WORD);
    endfunction

    // Bit 2 picks mapped-in, bit 3 word, bit 5 read
    function automatic logic op_map_in(input logic [7:0] op);
        return op[2];
    endfunction

    function automatic logic op_word(input logic [7:0] op);
        return op[3];
    endfunction

    function automatic logic op_read(input logic [7:0] op);
        return op[5];
    endfunction

    typedef enum logic [1:0] {
        BDU_S_IDLE,
        BDU_S_WAIT,
        BDU_S_ACCESS
    } bdu_state_t;

    bdu_state_t state;
    logic started;
    logic secured_boot;
    logic ack_on;
    logic halt_from_cmd;
    logic [1:0] halt_wait;
    logic [7:0] steal_cnt;
    logic [2:0] refuse_cnt;
    logic [7:0] cmd_op;
    logic [15:0] cmd_addr;
    logic [15:0] cmd_data;
    logic first_acc;

    logic cmd_take;
    logic cpu_cause;
    logic halt_cmd;
    logic st_wr;
    logic [7:0] status_val;
    logic [15:0] lane_rdata;
    logic issue;

    // ------------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------------
    // New commands ignored while one is underway; host must pace them
    assign cmd_take = i_cmd_valid && !o_busy;
    assign cpu_cause = i_halt_insn || i_ext_tag || i_brk_event;
    assign halt_cmd = cmd_take && (i_cmd.opcode == BDU_OP_ENTER_HALT);
    assign issue = (state == BDU_S_WAIT)
        && (i_cpu_bus_idle || steal_cnt == BDU_STEAL_LAST);

    // In-map write to the status register steers the enable bit
    assign st_wr = cmd_take && is_mem_op(i_cmd.opcode)
        && !op_read(i_cmd.opcode) && op_map_in(i_cmd.opcode)
        && (i_cmd.addr == BDU_STATUS_ADDR);

    always_comb begin
        status_val = BDU_STATUS_RESET;
        status_val[BDU_ST_ENABLE] = o_debug_enable;
        status_val[BDU_ST_ACTIVE] = o_active;
        status_val[BDU_ST_SECURED] = secured_boot;
        status_val[BDU_ST_ACK_ON] = ack_on;
        status_val[BDU_ST_UNSECURE_FLAG] = o_unsecure;
    end

    // Byte reads keep only the addressed lane
    always_comb begin
        lane_rdata = i_mem_rdata;
        if (!op_word(cmd_op)) begin
            if (cmd_addr[0]) begin
                lane_rdata = {8'h00, i_mem_rdata[7:0]};
            end else begin
                lane_rdata = {i_mem_rdata[15:8], 8'h00};
            end
        end
    end

    // ------------------------------------------------------------------
    // Straps and security
    // ------------------------------------------------------------------
    // Straps are caught on the first edge after reset release
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            started <= 1'b0;
            secured_boot <= 1'b0;
        end else if (!started) begin
            started <= 1'b1;
            secured_boot <= i_special_mode && i_secured;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_unsecure <= 1'b0;
        end else if (started && secured_boot && i_erase_ok) begin
            o_unsecure <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_debug_enable <= 1'b0;
        end else if (!started) begin
            // Secured parts wait for the erase check verdict
            o_debug_enable <= i_special_mode && !i_secured;
        end else if (secured_boot && (i_erase_ok || i_erase_fail)) begin
            o_debug_enable <= 1'b1;
        end else if (st_wr) begin
            // Status sits at an odd address, so it rides the low byte
            o_debug_enable <= i_cmd.data[BDU_ST_ENABLE];
        end
    end

    // ------------------------------------------------------------------
    // Activation and halt
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            halt_wait <= 2'd0;
            o_halt_req <= 1'b0;
            halt_from_cmd <= 1'b0;
        end else if (o_active || !o_debug_enable) begin
            halt_wait <= 2'd0;
            o_halt_req <= 1'b0;
            halt_from_cmd <= 1'b0;
        end else if (halt_wait == 2'd0 && (halt_cmd || cpu_cause)) begin
            // Breakpoint after-type waits one extra instruction
            halt_wait <= (i_brk_event && i_brk_after) ? 2'd2 : 2'd1;
            o_halt_req <= 1'b1;
            halt_from_cmd <= halt_cmd;
        end else if (halt_wait != 2'd0 && i_insn_done) begin
            halt_wait <= halt_wait - 2'd1;
            o_halt_req <= (halt_wait != 2'd1);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_active <= 1'b0;
        end else if (!started) begin
            o_active <= i_special_mode;
        end else if (halt_wait == 2'd1 && i_insn_done) begin
            o_active <= 1'b1;
        end else if (i_fw_resume) begin
            o_active <= 1'b0;
        end
    end

    // Disabled halt attempt from the CPU side costs a short stall only
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            refuse_cnt <= 3'd0;
            o_cpu_stall <= 1'b0;
        end else if (refuse_cnt != 3'd0) begin
            refuse_cnt <= refuse_cnt - 3'd1;
            o_cpu_stall <= (refuse_cnt != 3'd1);
        end else if (started && !o_debug_enable && cpu_cause) begin
            refuse_cnt <= BDU_REFUSE_LAST;
            o_cpu_stall <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_window_map <= 1'b0;
        end else begin
            o_window_map <= o_active;
        end
    end

    // Firmware commands need the halted state and an unsecured part
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fw_cmd_go <= 1'b0;
        end else begin
            o_fw_cmd_go <= i_fw_cmd_valid && o_active
                && (!secured_boot || o_unsecure);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_user_hidden <= 1'b0;
        end else begin
            o_user_hidden <= i_user_rd && in_regs(i_user_addr);
        end
    end

    // ------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_on <= 1'b0;
        end else if (cmd_take && i_cmd.opcode == BDU_OP_ACK_ON) begin
            ack_on <= 1'b1;
        end else if (cmd_take && i_cmd.opcode == BDU_OP_ACK_OFF) begin
            ack_on <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ack_pulse <= 1'b0;
        end else if (cmd_take && i_cmd.opcode == BDU_OP_ACK_ON) begin
            o_ack_pulse <= 1'b1;
        end else if (halt_from_cmd && halt_wait == 2'd1 && i_insn_done) begin
            o_ack_pulse <= ack_on;
        end else if (state == BDU_S_ACCESS && i_mem_done) begin
            o_ack_pulse <= ack_on;
        end else if (cmd_take && is_mem_op(i_cmd.opcode)
                     && op_map_in(i_cmd.opcode) && in_regs(i_cmd.addr)) begin
            o_ack_pulse <= ack_on;
        end else begin
            o_ack_pulse <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Memory access and cycle stealing
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= BDU_S_IDLE;
            cmd_op <= 8'h00;
            cmd_addr <= 16'h0000;
            cmd_data <= 16'h0000;
            steal_cnt <= 8'h00;
        end else begin
            case (state)
                BDU_S_IDLE: begin
                    steal_cnt <= 8'h00;
                    if (cmd_take && is_mem_op(i_cmd.opcode)) begin
                        cmd_op <= i_cmd.opcode;
                        cmd_data <= i_cmd.data;
                        // Words ignore the address lsb
                        cmd_addr <= op_word(i_cmd.opcode)
                            ? {i_cmd.addr[15:1], 1'b0} : i_cmd.addr;
                        // Own registers answer without the bus
                        if (!(op_map_in(i_cmd.opcode)
                              && in_regs(i_cmd.addr))) begin
                            state <= BDU_S_WAIT;
                        end
                    end
                end
                BDU_S_WAIT: begin
                    steal_cnt <= steal_cnt + 8'h01;
                    if (issue) begin
                        state <= BDU_S_ACCESS;
                    end
                end
                BDU_S_ACCESS: begin
                    if (i_mem_done) begin
                        state <= BDU_S_IDLE;
                    end
                end
                default: begin
                    state <= BDU_S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mem_req_valid <= 1'b0;
            o_mem_req <= '0;
            first_acc <= 1'b0;
        end else if (issue) begin
            o_mem_req_valid <= 1'b1;
            first_acc <= 1'b1;
            o_mem_req.addr <= cmd_addr;
            o_mem_req.wdata <= cmd_data;
            o_mem_req.write <= !op_read(cmd_op);
            o_mem_req.hi_en <= op_word(cmd_op) || !cmd_addr[0];
            o_mem_req.lo_en <= op_word(cmd_op) || cmd_addr[0];
            o_mem_req.map_in <= op_map_in(cmd_op);
        end else if (state == BDU_S_ACCESS) begin
            first_acc <= 1'b0;
            if (i_mem_done) begin
                o_mem_req_valid <= 1'b0;
                o_mem_req.map_in <= 1'b0;
            end
        end
    end

    // Freeze on a steal, or once an access outlasts its first cycle
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cpu_freeze <= 1'b0;
        end else if (issue) begin
            o_cpu_freeze <= !i_cpu_bus_idle;
        end else if (state == BDU_S_ACCESS) begin
            o_cpu_freeze <= !i_mem_done && (first_acc || o_cpu_freeze);
        end else begin
            o_cpu_freeze <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
        end else if (cmd_take && is_mem_op(i_cmd.opcode)
                     && !(op_map_in(i_cmd.opcode) && in_regs(i_cmd.addr))) begin
            o_busy <= 1'b1;
        end else if (state == BDU_S_ACCESS && i_mem_done) begin
            o_busy <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata_valid <= 1'b0;
            o_rdata <= 16'h0000;
        end else if (state == BDU_S_ACCESS && i_mem_done) begin
            o_rdata_valid <= op_read(cmd_op);
            if (op_read(cmd_op)) begin
                o_rdata <= lane_rdata;
            end
        end else if (cmd_take && is_mem_op(i_cmd.opcode)
                     && op_map_in(i_cmd.opcode) && in_regs(i_cmd.addr)) begin
            o_rdata_valid <= op_read(i_cmd.opcode);
            if (op_read(i_cmd.opcode)) begin
                // Status sits in the lane its address selects
                o_rdata <= (i_cmd.addr == BDU_STATUS_ADDR)
                    ? {8'h00, status_val} : 16'h0000;
            end
        end else begin
            o_rdata_valid <= 1'b0;
        end
    end

endmodule // bdu_core

`default_nettype wire

// [verilog/bdu_pkg.sv]
// Package for the background debug unit command core.
// Assumes a serial front end that delivers whole commands on the same clock.
package bdu_pkg;

    // ------------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] BDU_OP_ENTER_HALT = 8'h90;
    localparam logic [7:0] BDU_OP_ACK_ON = 8'hd5;
    localparam logic [7:0] BDU_OP_ACK_OFF = 8'hd6;
    localparam logic [7:0] BDU_OP_RD_IN_BYTE = 8'he4;
    localparam logic [7:0] BDU_OP_RD_IN_WORD = 8'hec;
    localparam logic [7:0] BDU_OP_RD_OUT_BYTE = 8'he0;
    localparam logic [7:0] BDU_OP_RD_OUT_WORD = 8'he8;
    localparam logic [7:0] BDU_OP_WR_IN_BYTE = 8'hc4;
    localparam logic [7:0] BDU_OP_WR_IN_WORD = 8'hcc;
    localparam logic [7:0] BDU_OP_WR_OUT_BYTE = 8'hc0;
    localparam logic [7:0] BDU_OP_WR_OUT_WORD = 8'hc8;

    // ------------------------------------------------------------------
    // Debug memory window
    // ------------------------------------------------------------------
    localparam logic [15:0] BDU_WIN_BASE = 16'hff00;
    localparam logic [15:0] BDU_WIN_LAST = 16'hffff;
    localparam logic [15:0] BDU_REG_BASE = 16'hff00;
    localparam logic [15:0] BDU_REG_LAST = 16'hff07;
    localparam logic [15:0] BDU_STATUS_ADDR = 16'hff01;

    // Debug status register field positions
    localparam int BDU_ST_ENABLE = 7;
    localparam int BDU_ST_ACTIVE = 6;
    localparam int BDU_ST_SECURED = 5;
    localparam int BDU_ST_ACK_ON = 4;
    localparam int BDU_ST_UNSECURE_FLAG = 1;
    localparam logic [7:0] BDU_STATUS_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int BDU_CLK_MHZ = 125;
    localparam int BDU_STEAL_WAIT_CYC = 128;
    localparam int BDU_REFUSE_DELAY_CYC = 4;
    localparam logic [7:0] BDU_STEAL_LAST = 8'(BDU_STEAL_WAIT_CYC - 1);
    localparam logic [2:0] BDU_REFUSE_LAST = 3'(BDU_REFUSE_DELAY_CYC - 1);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] opcode;
        logic [15:0] addr;
        logic [15:0] data;
    } bdu_cmd_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic write;
        logic hi_en;
        logic lo_en;
        logic map_in;
    } bdu_mem_req_t;

endpackage

// [sim/bdu_monitor.sv]
// Port checker for the debug command core.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module bdu_monitor
    import bdu_pkg::*;
(
    input wire logic i_sys_clk, i_reset_n, i_cmd_valid, o_busy,
    input wire bdu_pkg::bdu_cmd_t i_cmd,
    input wire logic i_user_rd, o_user_hidden, i_mem_done, i_fw_cmd_valid,
    input wire logic [15:0] i_user_addr,
    input wire logic o_mem_req_valid, o_cpu_freeze, o_ack_pulse, o_fw_cmd_go,
    input wire bdu_pkg::bdu_mem_req_t o_mem_req,
    input wire logic o_halt_req, o_active, o_window_map, o_debug_enable
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_take(logic [7:0] op);
        i_cmd_valid && !o_busy && i_cmd.opcode == op;
    endsequence
    AST_ACK_ON: assert property (s_take(BDU_OP_ACK_ON) |=> o_ack_pulse)
        else $error("no handshake after enable");
    AST_ACK_OFF: assert property (s_take(BDU_OP_ACK_OFF) |=> !o_ack_pulse)
        else $error("handshake after disable");
    AST_HALT_OFF: assert property (s_take(BDU_OP_ENTER_HALT)
        ##0 (!o_debug_enable && !o_active) |=> !o_halt_req && !o_active)
        else $error("halt taken while disabled");
    AST_BUS_BUSY: assert property (s_take(BDU_OP_RD_OUT_BYTE) |=> o_busy)
        else $error("bus read not underway");
    AST_STEAL_BOUND: assert property ($rose(o_busy)
        |-> ##[0:128] o_mem_req_valid) else $error("access waited too long");
    AST_DONE_END: assert property (o_mem_req_valid && i_mem_done
        |=> !o_mem_req_valid && !o_cpu_freeze) else $error("freeze outlived access");
    AST_WORD_ALIGN: assert property (s_take(BDU_OP_WR_OUT_WORD)
        |-> ##[1:129] (o_mem_req_valid && o_mem_req.hi_en && o_mem_req.lo_en
        && !o_mem_req.addr[0])) else $error("word write not aligned");
    AST_WINDOW: assert property (o_window_map == $past(o_active))
        else $error("window does not follow halt state");
    AST_HIDE: assert property (i_user_rd && i_user_addr inside
        {[BDU_REG_BASE:BDU_REG_LAST]} |=> o_user_hidden)
        else $error("user read of debug register not blocked");
    AST_FW_GO: assert property (o_fw_cmd_go
        |-> $past(i_fw_cmd_valid) && $past(o_active)) else $error("firmware ran");
endmodule // bdu_monitor
`default_nettype wire

// [sim/bdu_mem_model.sv]
// Memory fabric model answering borrowed accesses after mem_lat cycles.
// Read word is the inverted address; bus toggles when nothing is read.
`timescale 1ns/100ps
`default_nettype none
module bdu_mem_model
    import bdu_pkg::*;
(
    input wire logic i_sys_clk, i_reset_n, o_mem_req_valid,
    input wire bdu_pkg::bdu_mem_req_t o_mem_req,
    input wire logic [1:0] mem_lat,
    output logic i_mem_done,
    output logic [15:0] i_mem_rdata
);
    logic [1:0] cnt;
    logic ph;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= 2'h0;
            ph <= 1'b0;
        end else begin
            ph <= ~ph;
            cnt <= (o_mem_req_valid && !i_mem_done) ? cnt + 2'h1 : 2'h0;
        end
    end
    assign i_mem_done = o_mem_req_valid && cnt == mem_lat;
    assign i_mem_rdata = i_mem_done ? ~o_mem_req.addr : {8{ph, ~ph}};
endmodule // bdu_mem_model
`default_nettype wire

// [sim/single_wire_debug_command_unit_tb_top.sv]
// Bench for the debug command core with a memory model behind it.
// Inputs change at the falling edge; outputs sampled there too.
`timescale 1ns/100ps
`default_nettype none
module single_wire_debug_command_unit_tb_top;
    import bdu_pkg::*;
    logic i_sys_clk, i_reset_n, i_special_mode, i_secured, i_cmd_valid;
    logic i_fw_cmd_valid, i_erase_ok, i_erase_fail, i_halt_insn, i_insn_done;
    logic i_cpu_bus_idle, i_user_rd, i_mem_done, o_mem_req_valid, o_cpu_freeze;
    logic o_cpu_stall, o_halt_req, o_active, o_window_map, o_user_hidden;
    logic o_fw_cmd_go, o_rdata_valid, o_busy, o_ack_pulse, o_debug_enable;
    logic o_unsecure, stl, gos, frz;
    logic i_fw_resume = 1'b0, i_ext_tag = 1'b0;
    logic i_brk_event = 1'b0, i_brk_after = 1'b0;
    logic [15:0] i_user_addr, i_mem_rdata, o_rdata, rd;
    logic [1:0] mem_lat;
    bdu_cmd_t i_cmd;
    bdu_mem_req_t o_mem_req, rq;
    int n_fail = 0, compares = 0, n_ack, cyc = 0;
    bdu_core dut_u (.*);
    bdu_mem_model mem_u (.*);
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    always @(negedge i_sys_clk) begin
        if (o_ack_pulse) n_ack++;
        if (o_rdata_valid) rd = o_rdata;
        if (o_mem_req_valid) rq = o_mem_req;
        if (o_mem_req_valid && o_cpu_freeze) frz = 1'b1;
        if (o_cpu_stall) stl = 1'b1;
        if (o_fw_cmd_go) gos = 1'b1;
    end
    // Hang guard, well above the longest steal wait
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rst(input logic s, c);
        i_reset_n = 1'b0;
        i_special_mode = s;
        i_secured = c;
        repeat (6) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        repeat (2) @(negedge i_sys_clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge i_sys_clk);
        s = 1'b0;
        repeat (2) @(negedge i_sys_clk);
    endtask
    task automatic fw(input logic e);
        gos = 1'b0;
        pulse(i_fw_cmd_valid);
        chk(gos, e);
    endtask
    // Waits out the busy flag, so commands never overlap
    task automatic send(input logic [7:0] op, input logic [15:0] a, d);
        int k;
        n_ack = 0;
        frz = 1'b0;
        i_cmd = '{op, a, d};
        pulse(i_cmd_valid);
        for (k = 0; k < 300 && o_busy !== 1'b0; k++) begin
            @(negedge i_sys_clk);
        end
        @(negedge i_sys_clk);
    endtask
    task automatic t_disabled;
        rst(1'b0, 1'b0);
        stl = 1'b0;
        send(BDU_OP_ENTER_HALT, 16'h0000, 16'h0000);
        chk(o_halt_req, 1'b0);
        chk(stl, 1'b0);
        stl = 1'b0;
        pulse(i_halt_insn);
        chk(stl, 1'b1);
        fw(1'b0);
    endtask
    task automatic t_halt;
        send(BDU_OP_WR_IN_BYTE, BDU_STATUS_ADDR, 16'h8080);
        chk(o_debug_enable, 1'b1);
        send(BDU_OP_ACK_ON, 16'h0000, 16'h0000);
        chk(16'(n_ack), 16'h0001);
        send(BDU_OP_ENTER_HALT, 16'h0000, 16'h0000);
        chk(o_halt_req, 1'b1);
        pulse(i_insn_done);
        chk({o_active, 15'(n_ack)}, 16'h8001);
        fw(1'b1);
        send(BDU_OP_RD_IN_BYTE, BDU_STATUS_ADDR, 16'h0000);
        chk(rd, 16'h00d0);
        chk(16'(n_ack), 16'h0001);
        i_user_addr = 16'hff03;
        i_user_rd = 1'b1;
        @(negedge i_sys_clk);
        chk(o_user_hidden, 1'b1);
        i_user_rd = 1'b0;
        pulse(i_fw_resume);
        i_brk_after = 1'b1;
        pulse(i_brk_event);
        pulse(i_insn_done);
        chk({o_active, o_halt_req}, 2'b01);
        pulse(i_insn_done);
        chk({o_active, o_halt_req}, 2'b10);
        i_brk_after = 1'b0;
    endtask
    task automatic t_bus;
        send(BDU_OP_RD_OUT_BYTE, 16'h1235, 16'h0000);
        chk(rd, 16'h00ca);
        chk({frz, 15'(n_ack)}, 16'h0001);
        send(BDU_OP_RD_OUT_WORD, 16'h1235, 16'h0000);
        chk(rd, 16'hedcb);
        send(BDU_OP_WR_OUT_WORD, 16'h1235, 16'hbeef);
        chk(rq.addr, 16'h1234);
        chk(rq.wdata, 16'hbeef);
        chk({rq.write, rq.hi_en, rq.lo_en, rq.map_in}, 4'he);
        send(BDU_OP_WR_IN_BYTE, 16'h2001, 16'h0055);
        chk({rq.write, rq.hi_en, rq.lo_en, rq.map_in, 12'(n_ack)}, 16'hb001);
        mem_lat = 2'h2;
        send(BDU_OP_RD_IN_WORD, 16'h1234, 16'h0000);
        chk(rd, 16'hedcb);
        chk(frz, 1'b1);
        mem_lat = 2'h0;
        i_cpu_bus_idle = 1'b0;
        send(BDU_OP_RD_OUT_BYTE, 16'h1234, 16'h0000);
        chk(rd, 16'hed00);
        chk(frz, 1'b1);
        i_cpu_bus_idle = 1'b1;
        send(BDU_OP_ACK_OFF, 16'h0000, 16'h0000);
        chk(16'(n_ack), 16'h0000);
    endtask
    task automatic t_secure;
        rst(1'b1, 1'b1);
        chk({o_active, o_debug_enable}, 2'b10);
        pulse(i_erase_fail);
        chk({o_debug_enable, o_unsecure}, 2'b10);
        fw(1'b0);
        pulse(i_erase_ok);
        chk(o_unsecure, 1'b1);
        fw(1'b1);
        rst(1'b1, 1'b0);
        chk({o_active, o_debug_enable}, 2'b11);
    endtask
    initial begin
        {i_cmd_valid, i_fw_cmd_valid, i_erase_ok, i_erase_fail} = 4'h0;
        {i_halt_insn, i_insn_done, i_user_rd} = 3'h0;
        {i_cpu_bus_idle, mem_lat, i_cmd, i_user_addr} = '0;
        i_cpu_bus_idle = 1'b1;
        t_disabled();
        t_halt();
        t_bus();
        t_secure();
        tally_and_finish();
    end
endmodule // single_wire_debug_command_unit_tb_top
bind bdu_core bdu_monitor mon_u (.*);
`default_nettype wire
